// file: design/scmc_scan_chain_config_mcast.v
`timescale 1ns/10ps
`include "scmc_defs.vh"

// What this block does
// - group code register clears to 00 on entering test-logic-reset
// - group codes 00..11 map to addresses 3C, 3D, 3E, 3F hex
// - bridge becomes selected only when group address matches stored code
// - primary port configuration is an eight-bit data register
// - primary configuration loads 00000001 in test-logic-reset, port 0 only
// - bits 0,1,2,4,5,6 shape the chain; bit 3 only steers local clocks
// - all ports parked: input passes own register straight to output
// - release-ports command builds chain from selected local ports
// - bits 0..2 select ports 0..2, ascending, each followed by pad
// - bits 5 and 6 select ports 3 and 4 after port 2, padded
// - extended register low bits select ports 5..7 appended, padded
// - two-bit group code compared to address while awaiting address
// - bit 3 set and ports parked stops local test clocks
// - bit 4 set loops input through register to output, no ports
module scmc_scan_chain_config_mcast (
    input wire clk_sys_i,
    input wire reset_n_i,
    input wire tck_i,
    input wire tms_i,
    input wire tdi_i,
    input wire sel_port_config_primary_i,
    input wire sel_port_config_extended_i,
    input wire sel_group_code_i,
    input wire release_ports_cmd_i,
    input wire wait_for_address_i,
    input wire [7:0] ir_shift_value_i,
    input wire bridge_reg_tdo_i,
    input wire counter_status_i,
    input wire [`SCMC_NUM_PORTS-1:0] lsp_tdo_i,
    output reg tdo_o,
    output reg tdo_oe_o,
    output reg [`SCMC_NUM_PORTS-1:0] lsp_tdi_o,
    output reg lsp_tck_o,
    output wire local_tck_enable_o,
    output wire group_match_o,
    output reg group_selected_o,
    output wire test_logic_reset_o,
    output wire [7:0] port_config_primary_o,
    output wire [7:0] port_config_extended_o,
    output wire [1:0] multicast_group_code_o
);

    // tap states, one-hot
    localparam [15:0] ST_TLR = 16'h0001;
    localparam [15:0] ST_RTI = 16'h0002;
    localparam [15:0] ST_SEL_DR = 16'h0004;
    localparam [15:0] ST_CAP_DR = 16'h0008;
    localparam [15:0] ST_SH_DR = 16'h0010;
    localparam [15:0] ST_EX1_DR = 16'h0020;
    localparam [15:0] ST_PA_DR = 16'h0040;
    localparam [15:0] ST_EX2_DR = 16'h0080;
    localparam [15:0] ST_UPD_DR = 16'h0100;
    localparam [15:0] ST_SEL_IR = 16'h0200;
    localparam [15:0] ST_CAP_IR = 16'h0400;
    localparam [15:0] ST_SH_IR = 16'h0800;
    localparam [15:0] ST_EX1_IR = 16'h1000;
    localparam [15:0] ST_PA_IR = 16'h2000;
    localparam [15:0] ST_EX2_IR = 16'h4000;
    localparam [15:0] ST_UPD_IR = 16'h8000;

    localparam NP = `SCMC_NUM_PORTS;
    localparam IW = NP + 3;

    // pin synchronisers: tck, tms, tdi, local returns
    reg [IW-1:0] sync1_r, sync2_r, sync3_r, flt_r;
    wire [IW-1:0] flt_nxt;
    wire tck_f, tms_f, tdi_f;
    wire [NP-1:0] lsp_tdo_f;
    reg tck_d_r;
    wire tck_rise, tck_fall;

    reg [15:0] state_r, state_nxt;

    // live settings beside their shift stages
    reg [7:0] pri_r, ext_r, pri_sh_r, ext_sh_r;
    reg [1:0] grp_r, grp_sh_r;
    reg [NP-1:0] pad_r;

    reg own_tdo, chain_tdo, node;
    reg [NP-1:0] tdi_nxt;
    integer i;

    wire [NP-1:0] port_sel;
    wire unparked, in_shift;

    // a level counts only once the second and third stages agree
    assign flt_nxt = (sync2_r & ~(sync2_r ^ sync3_r)) |
                     (flt_r & (sync2_r ^ sync3_r));
    assign tck_f = flt_r[0];
    assign tms_f = flt_r[1];
    assign tdi_f = flt_r[2];
    assign lsp_tdo_f = flt_r[IW-1:3];
    assign tck_rise = tck_f & ~tck_d_r;
    assign tck_fall = ~tck_f & tck_d_r;

    always @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            sync1_r <= {IW{1'b0}};
            sync2_r <= {IW{1'b0}};
            sync3_r <= {IW{1'b0}};
            flt_r <= {IW{1'b0}};
            tck_d_r <= 1'b0;
        end
        else
        begin
            sync1_r <= {lsp_tdo_i, tdi_i, tms_i, tck_i};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            flt_r <= flt_nxt;
            tck_d_r <= tck_f;
        end
    end

    // standard tap state sequencing on each test clock rise
    always @*
    begin
        case (state_r)
            ST_TLR: state_nxt = tms_f ? ST_TLR : ST_RTI;
            ST_RTI: state_nxt = tms_f ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: state_nxt = tms_f ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_nxt = tms_f ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: state_nxt = tms_f ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_nxt = tms_f ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR: state_nxt = tms_f ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: state_nxt = tms_f ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_nxt = tms_f ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: state_nxt = tms_f ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: state_nxt = tms_f ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: state_nxt = tms_f ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_nxt = tms_f ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR: state_nxt = tms_f ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: state_nxt = tms_f ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_nxt = tms_f ? ST_SEL_DR : ST_RTI;
            default: state_nxt = ST_TLR;
        endcase
    end

    always @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            state_r <= ST_TLR;
        else if (tck_rise)
            state_r <= state_nxt;
    end

    assign test_logic_reset_o = (state_r == ST_TLR);
    assign in_shift = (state_r == ST_SH_DR) || (state_r == ST_SH_IR);

    // group address match; the base keeps the code in the low two bits
    assign group_match_o = wait_for_address_i &&
        (ir_shift_value_i == {`SCMC_GROUP_ADDR_BASE, grp_r});

    // selection latched at update-ir; a foreign group stays unselected
    always @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            group_selected_o <= 1'b0;
        else if (state_r == ST_TLR)
            group_selected_o <= 1'b0;
        else if (tck_rise && state_r == ST_UPD_IR && wait_for_address_i)
            group_selected_o <= group_match_o;
    end

    // capture / shift / update of the three configuration registers
    always @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            pri_r <= `SCMC_PRIMARY_RESET;
            ext_r <= `SCMC_EXTENDED_RESET;
            grp_r <= `SCMC_GROUP_RESET;
            pri_sh_r <= 8'h00;
            ext_sh_r <= 8'h00;
            grp_sh_r <= 2'h0;
        end
        else if (state_r == ST_TLR)
        begin
            pri_r <= `SCMC_PRIMARY_RESET;
            ext_r <= `SCMC_EXTENDED_RESET;
            grp_r <= `SCMC_GROUP_RESET;
        end
        else if (tck_rise)
        begin
            case (state_r)
                ST_CAP_DR:
                begin
                    // status bit is read back live, never stored
                    pri_sh_r <= {counter_status_i, pri_r[6:0]};
                    ext_sh_r <= ext_r;
                    grp_sh_r <= grp_r;
                end
                ST_SH_DR:
                begin
                    if (sel_port_config_primary_i)
                        pri_sh_r <= {tdi_f, pri_sh_r[7:1]};
                    if (sel_port_config_extended_i)
                        ext_sh_r <= {tdi_f, ext_sh_r[7:1]};
                    if (sel_group_code_i)
                        grp_sh_r <= {tdi_f, grp_sh_r[1]};
                end
                ST_UPD_DR:
                begin
                    // settings change here or in test-logic-reset only, so a long shift is harmless
                    if (sel_port_config_primary_i)
                        pri_r <= {1'b0, pri_sh_r[6:0]};
                    if (sel_port_config_extended_i)
                        ext_r <= {5'h00, ext_sh_r[2:0]};
                    if (sel_group_code_i)
                        grp_r <= grp_sh_r;
                end
                default:
                    pri_sh_r <= pri_sh_r;
            endcase
        end
    end

    assign port_config_primary_o = {counter_status_i, pri_r[6:0]};
    assign port_config_extended_o = ext_r;
    assign multicast_group_code_o = grp_r;

    // port order: 0,1,2 then 3,4 then 5,6,7
    assign port_sel = {ext_r[`SCMC_EXT_PORT7:`SCMC_EXT_PORT5],
                       pri_r[`SCMC_PRI_PORT4:`SCMC_PRI_PORT3],
                       pri_r[`SCMC_PRI_PORT2:`SCMC_PRI_PORT0]};
    // bit 3 is left out of the chain, it gates clocks only
    assign unparked = release_ports_cmd_i &&
                      !pri_r[`SCMC_PRI_LOOPBACK];

    // chain walk: own register, then each selected port and its pad
    always @*
    begin
        own_tdo = bridge_reg_tdo_i;
        if (sel_port_config_primary_i)
            own_tdo = pri_sh_r[0];
        else if (sel_port_config_extended_i)
            own_tdo = ext_sh_r[0];
        else if (sel_group_code_i)
            own_tdo = grp_sh_r[0];
        node = own_tdo;
        tdi_nxt = {NP{1'b0}};
        for (i = 0; i < NP; i = i + 1)
        begin
            tdi_nxt[i] = node;
            if (unparked && port_sel[i])
                node = pad_r[i];
        end
        // parked or looped back: node never left the own register
        chain_tdo = node;
    end

    // pads sample on the rise; outputs change on the fall
    always @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            pad_r <= {NP{1'b0}};
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
            lsp_tdi_o <= {NP{1'b0}};
        end
        else
        begin
            if (tck_rise)
                pad_r <= lsp_tdo_f;
            if (tck_fall)
            begin
                tdo_o <= chain_tdo;
                tdo_oe_o <= in_shift;
                lsp_tdi_o <= tdi_nxt;
            end
        end
    end

    // a parked port with bit 3 set gets no clock, saving power
    assign local_tck_enable_o = release_ports_cmd_i |
                                ~pri_r[`SCMC_PRI_TCK_STOP];

    // local clock is re-timed, so it lags the backplane clock slightly
    always @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
            lsp_tck_o <= 1'b0;
        else
            lsp_tck_o <= tck_f & local_tck_enable_o;
    end

endmodule

// file: design/scmc_defs.vh
`ifndef SCMC_DEFS_VH
`define SCMC_DEFS_VH

// number of local scan ports in the largest build
`define SCMC_NUM_PORTS 8

// reset values loaded on entering test-logic-reset
`define SCMC_GROUP_RESET 2'h0
`define SCMC_PRIMARY_RESET 8'h01
`define SCMC_EXTENDED_RESET 8'h00

// primary port configuration field positions
`define SCMC_PRI_PORT0 0
`define SCMC_PRI_PORT2 2
`define SCMC_PRI_TCK_STOP 3
`define SCMC_PRI_LOOPBACK 4
`define SCMC_PRI_PORT3 5
`define SCMC_PRI_PORT4 6
`define SCMC_PRI_CNT_STATUS 7

// extended port configuration field positions (ports 5 to 7)
`define SCMC_EXT_PORT5 0
`define SCMC_EXT_PORT7 2

// upper six bits of every group address; low two bits are the code
`define SCMC_GROUP_ADDR_BASE 6'h0f

// widths
`define SCMC_CFG_W 8
`define SCMC_GROUP_W 2

`endif

// file: bench/scmc_asserts.sv
`timescale 1ns/10ps
// checker on the configuration ports of the bridge
module scmc_asserts (
    input wire clk_sys_i,
    input wire reset_n_i,
    input wire sel_port_config_primary_i,
    input wire sel_group_code_i,
    input wire release_ports_cmd_i,
    input wire wait_for_address_i,
    input wire counter_status_i,
    input wire [7:0] ir_shift_value_i,
    input wire lsp_tck_o,
    input wire local_tck_enable_o,
    input wire group_match_o,
    input wire group_selected_o,
    input wire test_logic_reset_o,
    input wire [7:0] port_config_primary_o,
    input wire [7:0] port_config_extended_o,
    input wire [1:0] multicast_group_code_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    // group addresses sit at 3c upward, one per stored code
    grp_addr_a: assert property (group_match_o == (wait_for_address_i
        && ir_shift_value_i == 8'h3c + {6'h00, multicast_group_code_o}))
        else $error("group match wrong");
    tlr_reload_a: assert property (test_logic_reset_o |=>
        port_config_primary_o[6:0] == 7'h01 && !group_selected_o
        && port_config_extended_o == 8'h00 && multicast_group_code_o == 2'h0)
        else $error("reset values wrong");
    pri_status_a: assert property (port_config_primary_o[7] ==
        counter_status_i) else $error("status bit wrong");
    ext_rsvd_a: assert property (port_config_extended_o[7:3] == 5'h00)
        else $error("extended reserved bits set");
    tck_en_a: assert property (local_tck_enable_o == (release_ports_cmd_i
        || !port_config_primary_o[3])) else $error("clock enable wrong");
    tck_stop_a: assert property (!local_tck_enable_o [*2] |-> !lsp_tck_o)
        else $error("local clock runs while stopped");
    pri_hold_a: assert property ($changed(port_config_primary_o[6:0]) |->
        $past(sel_port_config_primary_i) || $past(test_logic_reset_o))
        else $error("primary changed unselected");
    grp_hold_a: assert property ($changed(multicast_group_code_o) |->
        $past(sel_group_code_i) || $past(test_logic_reset_o))
        else $error("group code changed unselected");
    grp_sel_a: assert property ($rose(group_selected_o) |->
        $past(group_match_o)) else $error("selected without match");
    cover property ($rose(group_selected_o));
    cover property (!local_tck_enable_o);
    cover property ($changed(port_config_extended_o));
endmodule

bind scmc_scan_chain_config_mcast scmc_asserts i_asserts (.*);

// file: bench/scmc_tap_master.sv
`timescale 1ns/10ps
// backplane test master; tck stands still between frames
module scmc_tap_master (
    input wire clk_sys_i,
    output reg tck_o,
    output reg tms_o,
    output reg tdi_o
);
    initial
    begin
        tck_o = 1'h0;
        tms_o = 1'h1;
        tdi_o = 1'h0;
    end
    // one 32 ns period; tms and tdi move with the fall for full setup
    task step(input logic m, input logic d);
        begin
            @(posedge clk_sys_i);
            tck_o <= 1'h0;
            tms_o <= m;
            tdi_o <= d;
            repeat (4) @(posedge clk_sys_i);
            tck_o <= 1'h1;
            repeat (3) @(posedge clk_sys_i);
        end
    endtask
    // lsb first; tms high on the last bit leaves shift
    task shift(input logic [7:0] v, input int n);
        int i;
        begin
            for (i = 0; i < n; i = i + 1)
                step(i == n - 1, v[i]);
        end
    endtask
    // rti to shift-dr, bits, update, back to rti
    task write_dr(input logic [7:0] v, input int n);
        begin
            step(1, 0);
            step(0, 0);
            step(0, 0);
            shift(v, n);
            step(1, 0);
            step(0, 0);
            settle;
        end
    endtask
    task write_ir;
        begin
            step(1, 0);
            step(1, 0);
            step(0, 0);
            step(0, 0);
            shift(8'h00, 8);
            step(1, 0);
            step(0, 0);
            settle;
        end
    endtask
    // five tms highs always reach test-logic-reset, then rti
    task go_tlr;
        begin
            repeat (5) step(1, 0);
            step(0, 0);
        end
    endtask
    task idle_shift;
        begin
            step(1, 0);
            step(0, 0);
            repeat (5) step(0, 0);
        end
    endtask
    // the last rise needs the pin filter delay before selects may move
    task settle;
        begin
            repeat (3) @(posedge clk_sys_i);
        end
    endtask
endmodule

// file: bench/scmc_scan_chain_config_mcast_bench.sv
`timescale 1ns/10ps
module scmc_scan_chain_config_mcast_bench;
    reg clk_sys_i = 1'h0;
    reg reset_n_i = 1'h0;
    reg sel_port_config_primary_i = 1'h0;
    reg sel_port_config_extended_i = 1'h0;
    reg sel_group_code_i = 1'h0;
    reg release_ports_cmd_i = 1'h0;
    reg wait_for_address_i = 1'h0;
    reg [7:0] ir_shift_value_i = 8'h00;
    reg bridge_reg_tdo_i = 1'h1;
    reg counter_status_i = 1'h0;
    reg [7:0] lsp_tdo_i = 8'h00;
    wire tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, lsp_tck_o, local_tck_enable_o;
    wire group_match_o, group_selected_o, test_logic_reset_o;
    wire [7:0] lsp_tdi_o, port_config_primary_o, port_config_extended_o;
    wire [1:0] multicast_group_code_o;
    reg [25:0] rows [0:9];
    reg [25:0] r;
    integer num_errors = 0, num_checks = 0, cyc = 0, i;
    scmc_scan_chain_config_mcast i_dut (.*);
    scmc_tap_master i_master (.clk_sys_i(clk_sys_i), .tck_o(tck_i),
        .tms_o(tms_i), .tdi_o(tdi_i));
    always #2 clk_sys_i = ~clk_sys_i;
    task chk(input logic [7:0] g, input logic [7:0] e);
        begin
            num_checks = num_checks + 1;
            if (g !== e)
            begin
                num_errors = num_errors + 1;
                $display("Error at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d errors %0d", num_checks, num_errors);
            if (num_errors == 0 && num_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    // whole run needs about 3700 cycles; beyond 30000 it hangs
    always @(posedge clk_sys_i)
    begin
        cyc = cyc + 1;
        if (cyc == 30000)
        begin
            num_errors = num_errors + 1;
            finish_test;
        end
    end
    // release, primary, extended, port returns, expected serial out
    initial
    begin
        rows[0] = {1'h0, 8'h0f, 8'h00, 8'h00, 1'h1};
        rows[1] = {1'h1, 8'h00, 8'h00, 8'h00, 1'h1};
        rows[2] = {1'h1, 8'h01, 8'h00, 8'hfe, 1'h0};
        rows[3] = {1'h1, 8'h07, 8'h00, 8'hfb, 1'h0};
        rows[4] = {1'h1, 8'h60, 8'h00, 8'hef, 1'h0};
        rows[5] = {1'h1, 8'h67, 8'h00, 8'hf7, 1'h1};
        rows[6] = {1'h1, 8'h00, 8'hfc, 8'h7f, 1'h0};
        rows[7] = {1'h1, 8'h67, 8'h01, 8'hdf, 1'h0};
        rows[8] = {1'h1, 8'h17, 8'h00, 8'h00, 1'h1};
        rows[9] = {1'h1, 8'h09, 8'h00, 8'hfe, 1'h0};
        repeat (16) @(posedge clk_sys_i);
        reset_n_i <= 1'h1;
        repeat (4) @(posedge clk_sys_i);
        chk(port_config_primary_o, 8'h01);
        chk(port_config_extended_o, 8'h00);
        chk({6'h00, multicast_group_code_o}, 8'h00);
        $display("reset test done");
        for (i = 0; i < 10; i = i + 1)
        begin
            r = rows[i];
            @(posedge clk_sys_i);
            release_ports_cmd_i <= r[25];
            lsp_tdo_i <= r[8:1];
            i_master.go_tlr;
            sel_port_config_extended_i <= 1'h1;
            i_master.write_dr(r[16:9], 8);
            sel_port_config_extended_i <= 1'h0;
            sel_port_config_primary_i <= 1'h1;
            i_master.write_dr(r[24:17], 8);
            sel_port_config_primary_i <= 1'h0;
            i_master.idle_shift;
            chk({7'h00, tdo_o}, {7'h00, r[0]});
            chk({7'h00, local_tck_enable_o}, {7'h00, r[25] | ~r[20]});
            chk(port_config_primary_o, {1'h0, r[23:17]});
            chk(port_config_extended_o, {5'h00, r[11:9]});
            chk({7'h00, tdo_oe_o}, 8'h01);
            chk({7'h00, lsp_tdi_o[0]}, 8'h01);
        end
        $display("chain table done");
        // old setting holds until update-dr is left
        i_master.go_tlr;
        counter_status_i <= 1'h1;
        sel_port_config_primary_i <= 1'h1;
        i_master.step(1, 0);
        i_master.step(0, 0);
        i_master.step(0, 0);
        i_master.shift(8'h7e, 8);
        chk(port_config_primary_o, 8'h81);
        i_master.step(1, 0);
        chk(port_config_primary_o, 8'h81);
        i_master.step(0, 0);
        i_master.settle;
        chk(port_config_primary_o, 8'hfe);
        sel_port_config_primary_i <= 1'h0;
        counter_status_i <= 1'h0;
        $display("update test done");
        // bridge is given its group code on its own first
        sel_group_code_i <= 1'h1;
        i_master.write_dr(8'h02, 2);
        sel_group_code_i <= 1'h0;
        chk({6'h00, multicast_group_code_o}, 8'h02);
        wait_for_address_i <= 1'h1;
        for (i = 0; i < 4; i = i + 1)
        begin
            ir_shift_value_i <= 8'h3c + i[7:0];
            repeat (2) @(posedge clk_sys_i);
            chk({7'h00, group_match_o}, {7'h00, i == 2});
        end
        ir_shift_value_i <= 8'h3d;
        i_master.write_ir;
        chk({7'h00, group_selected_o}, 8'h00);
        ir_shift_value_i <= 8'h3e;
        i_master.write_ir;
        chk({7'h00, group_selected_o}, 8'h01);
        wait_for_address_i <= 1'h0;
        i_master.go_tlr;
        chk({6'h00, multicast_group_code_o}, 8'h00);
        chk({7'h00, group_selected_o}, 8'h00);
        $display("group test done");
        finish_test;
    end
endmodule
